// >>> shared/mbag_params.svh
`ifndef MBAG_PARAMS_SVH
`define MBAG_PARAMS_SVH
// ***************************************************
// widths and counts
// ***************************************************
`define MBAG_VA_W        16
`define MBAG_PA_W        16
`define MBAG_SEG_CNT     64
`define MBAG_SEG_IDX_W   6
`define MBAG_SFR_ADDR_W  8
`define MBAG_HW_GRP_W    16
// rights field positions in a segment entry
`define MBAG_RIGHT_R     0
`define MBAG_RIGHT_W     1
`define MBAG_RIGHT_X     2
// sfr group field position within an sfr address
`define MBAG_SFR_GRP_LSB 5
`define MBAG_SFR_HW_LSB  0
`define MBAG_SFR_HW_W    4
// reset values
`define MBAG_RST_SEG     6'h00
`endif

// >>> shared/mbag_pkg.sv
`default_nettype none
`include "mbag_params.svh"
package mbag_pkg;
    // cpu execution modes, entered in sequence
    typedef enum logic [2:0] {MBAG_BOOT, MBAG_TEST, MBAG_FW, MBAG_SYS, MBAG_USER} mbag_mode_t;
    // memory operation kinds
    typedef enum logic [1:0] {MBAG_OP_READ, MBAG_OP_WRITE, MBAG_OP_FETCH} mbag_op_t;
    // sfr groups encoded in the upper sfr address bits
    typedef enum logic [2:0] {MBAG_G_MMU, MBAG_G_SYSMGT, MBAG_G_FWCFG, MBAG_G_FWOS,
                              MBAG_G_TEST, MBAG_G_HW, MBAG_G_CPU, MBAG_G_CPUSU} mbag_grp_t;
    // one segment table entry
    typedef struct packed {
        logic [2:0]                   rights;
        logic [`MBAG_VA_W-1:0]        first_va;
        logic [`MBAG_VA_W-1:0]        last_va;
        logic [`MBAG_PA_W-1:0]        reloc;
        logic [`MBAG_HW_GRP_W-1:0]    hw_rd;
        logic [`MBAG_HW_GRP_W-1:0]    hw_wr;
    } mbag_seg_t;
    // memory request from the cpu
    typedef struct packed {
        logic                         valid;
        mbag_op_t                     op;
        logic [`MBAG_VA_W-1:0]        va;
        logic [31:0]                  wdata;
    } mbag_mreq_t;
    // sfr request from the cpu
    typedef struct packed {
        logic                         valid;
        logic                         wr;
        logic [`MBAG_SFR_ADDR_W-1:0]  addr;
    } mbag_sreq_t;
    // memory request towards the memories
    typedef struct packed {
        logic                         valid;
        mbag_op_t                     op;
        logic [`MBAG_PA_W-1:0]        pa;
        logic [31:0]                  wdata;
    } mbag_preq_t;
endpackage
`default_nettype wire

// >>> src/mbag_seg_mem.sv
`default_nettype none
`include "mbag_params.svh"
// ***************************************************
// segment table store, registered read port
// ***************************************************
module mbag_seg_mem
    import mbag_pkg::*;
(
    // clock and reset
    input  wire logic                       clock_in,
    input  wire logic                       sys_rst_in,
    // write port
    input  wire logic                       wr_en_in,
    input  wire logic [`MBAG_SEG_IDX_W-1:0] wr_idx_in,
    input  wire mbag_seg_t                  wr_data_in,
    // read port
    input  wire logic [`MBAG_SEG_IDX_W-1:0] rd_idx_in,
    output mbag_seg_t                       rd_data_out
);
    mbag_seg_t mem [`MBAG_SEG_CNT];
    // storage, rights cleared at reset so every segment starts unused
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < `MBAG_SEG_CNT; i++) begin
                mem[i] <= '0;
            end
        end else if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end
    // registered read
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_out <= '0;
        end else begin
            rd_data_out <= mem[rd_idx_in];
        end
    end
endmodule
`default_nettype wire

// >>> src/mbag_guard.sv
`default_nettype none
`include "mbag_params.svh"
// Summary of operation
// - policy covers all code, memories, operations
// - translate virtual to physical before access, in user mode only
// - check first, forward only when permitted
// - policy covers every sfr read, write
// - per-register check using current cpu mode
// - user, firmware hw rights from table, firewall
// - refused sfr access raises an exception
// - read/write forbidden by function or mode
// - guard enforces sfr permission for the peripheral
// - five modes boot, test, fw, sys, user
// - up to 64 segments with rights, bounds
// - segment without rights is unused
module mbag_guard
    import mbag_pkg::*;
(
    // clock and reset
    input  wire logic                       clock_in,
    input  wire logic                       sys_rst_in,
    // mode and firewall configuration
    input  wire mbag_mode_t                 mode_in,
    input  wire logic [`MBAG_HW_GRP_W-1:0]  fw_hw_rd_in,
    input  wire logic [`MBAG_HW_GRP_W-1:0]  fw_hw_wr_in,
    // segment table load and selection
    input  wire logic                       seg_wr_en_in,
    input  wire logic [`MBAG_SEG_IDX_W-1:0] seg_wr_idx_in,
    input  wire mbag_seg_t                  seg_wr_data_in,
    input  wire logic [`MBAG_SEG_IDX_W-1:0] seg_sel_in,
    // cpu memory request (virtual)
    input  wire mbag_mreq_t                 mreq_in,
    // memory side request (physical)
    output mbag_preq_t                      preq_out,
    // cpu sfr request and peripheral strobes
    input  wire mbag_sreq_t                 sreq_in,
    output logic                            sfr_rd_out,
    output logic                            sfr_wr_out,
    output logic [`MBAG_SFR_ADDR_W-1:0]     sfr_addr_out,
    // exceptions
    output logic                            mem_exc_out,
    output logic                            sfr_exc_out
);
    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        mbag_preq_t                    preq;
        logic                          srd;
        logic                          swr;
        logic [`MBAG_SFR_ADDR_W-1:0]   saddr;
        logic                          mexc;
        logic                          sexc;
    } mbag_state_t;

    mbag_state_t st_r, st_nxt;
    mbag_seg_t   seg;

    // segment table of the active segment
    mbag_seg_mem u_seg (
        .clock_in    (clock_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (seg_wr_en_in),
        .wr_idx_in   (seg_wr_idx_in),
        .wr_data_in  (seg_wr_data_in),
        .rd_idx_in   (seg_sel_in),
        .rd_data_out (seg)
    );

    // ***************************************************
    // permission functions
    // ***************************************************
    // memory rights by mode; user mode goes through segment entry
    function automatic logic mem_ok(input mbag_mode_t m, input mbag_op_t op,
                                    input mbag_seg_t s, input logic [`MBAG_VA_W-1:0] va);
        logic in_rng;
        logic used;
        in_rng = (va >= s.first_va) && (va <= s.last_va);
        used   = |s.rights;
        if (m != MBAG_USER) begin
            return 1'b1;
        end
        unique case (op)
            MBAG_OP_READ:  return used && in_rng && s.rights[`MBAG_RIGHT_R];
            MBAG_OP_WRITE: return used && in_rng && s.rights[`MBAG_RIGHT_W];
            MBAG_OP_FETCH: return used && in_rng && s.rights[`MBAG_RIGHT_X];
            default:       return 1'b0;
        endcase
    endfunction

    // sfr rights per group and mode
    function automatic logic sfr_ok(input mbag_mode_t m, input logic wr,
                                    input logic [`MBAG_SFR_ADDR_W-1:0] a,
                                    input mbag_seg_t s,
                                    input logic [`MBAG_HW_GRP_W-1:0] frd,
                                    input logic [`MBAG_HW_GRP_W-1:0] fwr);
        mbag_grp_t g;
        logic [`MBAG_SFR_HW_W-1:0] h;
        g = mbag_grp_t'(a[`MBAG_SFR_ADDR_W-1:`MBAG_SFR_GRP_LSB]);
        h = a[`MBAG_SFR_HW_LSB +: `MBAG_SFR_HW_W];
        if (g == MBAG_G_CPU) begin
            return 1'b1;
        end
        unique case (m)
            MBAG_BOOT: return !(g inside {MBAG_G_TEST, MBAG_G_MMU, MBAG_G_CPUSU});
            MBAG_TEST: return !(g inside {MBAG_G_MMU, MBAG_G_CPUSU});
            MBAG_FW:   return (g == MBAG_G_FWOS) || (g == MBAG_G_FWCFG && !wr) ||
                              (g == MBAG_G_HW && (wr ? fwr[h] : frd[h]));
            MBAG_SYS:  return g inside {MBAG_G_MMU, MBAG_G_SYSMGT, MBAG_G_FWCFG, MBAG_G_HW, MBAG_G_CPUSU};
            MBAG_USER: return (g == MBAG_G_CPUSU) ||
                              (g == MBAG_G_HW && (|s.rights) && (wr ? s.hw_wr[h] : s.hw_rd[h]));
            default:   return 1'b0;
        endcase
    endfunction

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        logic mok;
        logic sok;
        mok = mem_ok(mode_in, mreq_in.op, seg, mreq_in.va);
        sok = sfr_ok(mode_in, sreq_in.wr, sreq_in.addr, seg, fw_hw_rd_in, fw_hw_wr_in);
        st_nxt = st_r;
        // memory path: forward translated address only when allowed
        st_nxt.preq.valid = mreq_in.valid && mok;
        st_nxt.preq.op    = mreq_in.op;
        st_nxt.preq.pa    = (mode_in == MBAG_USER) ? `MBAG_PA_W'(mreq_in.va + seg.reloc) : mreq_in.va;
        st_nxt.preq.wdata = mreq_in.wdata;
        st_nxt.mexc       = mreq_in.valid && !mok;
        // sfr path: strobes only when allowed, exception otherwise
        st_nxt.srd   = sreq_in.valid && !sreq_in.wr && sok;
        st_nxt.swr   = sreq_in.valid && sreq_in.wr && sok;
        st_nxt.saddr = sreq_in.addr;
        st_nxt.sexc  = sreq_in.valid && !sok;
    end

    // state register
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign preq_out     = st_r.preq;
    assign sfr_rd_out   = st_r.srd;
    assign sfr_wr_out   = st_r.swr;
    assign sfr_addr_out = st_r.saddr;
    assign mem_exc_out  = st_r.mexc;
    assign sfr_exc_out  = st_r.sexc;

    // ***************************************************
    // assertions
    // ***************************************************
    sequence s_sfr_deny;
        sreq_in.valid && !sfr_ok(mode_in, sreq_in.wr, sreq_in.addr, seg, fw_hw_rd_in, fw_hw_wr_in);
    endsequence
    a_sfr_deny_exc: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        s_sfr_deny |=> sfr_exc_out && !sfr_rd_out && !sfr_wr_out) else $error("denied sfr no exception");
    a_sfr_excl: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !(sfr_exc_out && (sfr_rd_out || sfr_wr_out))) else $error("sfr strobe with exception");
    a_mem_excl: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !(mem_exc_out && preq_out.valid)) else $error("memory forwarded with exception");
    a_user_unused: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        mreq_in.valid && mode_in == MBAG_USER && seg.rights == 3'h0 |=> mem_exc_out)
        else $error("unused segment access allowed");
    a_user_xlate: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        mreq_in.valid && mode_in == MBAG_USER |=> preq_out.pa == $past(mreq_in.va) + $past(seg.reloc))
        else $error("bad translation");
    a_user_ro: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        mreq_in.valid && mode_in == MBAG_USER && mreq_in.op == MBAG_OP_WRITE && !seg.rights[`MBAG_RIGHT_W]
        |=> !preq_out.valid) else $error("write without right");
    a_boot_test: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        sreq_in.valid && mode_in == MBAG_BOOT && sreq_in.addr[7:5] == 3'h4 |=> sfr_exc_out)
        else $error("boot reached test sfr");
    a_mem_pass: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        mreq_in.valid && mode_in == MBAG_SYS |=> preq_out.valid && !mem_exc_out)
        else $error("system access refused");
    a_mem_answer: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        mreq_in.valid |=> preq_out.valid != mem_exc_out) else $error("memory request not answered once");
    a_mem_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !mreq_in.valid |=> !preq_out.valid && !mem_exc_out) else $error("memory answer without request");
    a_sfr_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        !sreq_in.valid |=> !sfr_rd_out && !sfr_wr_out && !sfr_exc_out) else $error("sfr answer without request");
    a_sfr_cpu_grp: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        sreq_in.valid && sreq_in.addr[7:5] == 3'h6 |=> (sfr_rd_out || sfr_wr_out)) else $error("cpu sfr refused");
endmodule
`default_nettype wire

// >>> verif/mbag_cpu_model.sv
`default_nettype none
`include "mbag_params.svh"
// ***************************************************
// cpu core model: virtual requests, one cycle each
// ***************************************************
module mbag_cpu_model
    import mbag_pkg::*;
(
    // clock
    input  wire logic clock_in,
    // requests towards the guard
    output var  mbag_mreq_t mreq_out,
    output var  mbag_sreq_t sreq_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until the bench asks
    initial begin
        mreq_out = '0;
        sreq_out = '0;
    end

    // memory request, virtual address only
    task automatic mem_req(input mbag_op_t op, input logic [`MBAG_VA_W-1:0] va);
        @(posedge clock_in);
        #1;
        mreq_out = '{valid: 1'b1, op: op, va: va, wdata: {2{va}}};
        @(posedge clock_in);
        #1;
        mreq_out.valid = 1'b0;
        mreq_out.va    = ~va;              // released lines show the inverse
        mreq_out.wdata = ~mreq_out.wdata;
    endtask

    // register request, read or write
    task automatic sfr_req(input logic wr, input logic [`MBAG_SFR_ADDR_W-1:0] a);
        @(posedge clock_in);
        #1;
        sreq_out = '{valid: 1'b1, wr: wr, addr: a};
        @(posedge clock_in);
        #1;
        sreq_out.valid = 1'b0;
        sreq_out.addr  = ~a;
        sreq_out.wr    = ~wr;
    endtask
endmodule
`default_nettype wire

// >>> verif/test_mode_based_access_guard.sv
`default_nettype none
`include "mbag_params.svh"
// ***************************************************
// bench for the mode based access guard
// ***************************************************
module test_mode_based_access_guard
    import mbag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clock_in;
    logic        sys_rst_in;
    mbag_mode_t  mode_in;
    logic [15:0] fw_hw_rd_in;
    logic [15:0] fw_hw_wr_in;
    logic        seg_wr_en_in;
    logic [5:0]  seg_wr_idx_in;
    mbag_seg_t   seg_wr_data_in;
    logic [5:0]  seg_sel_in;
    mbag_mreq_t  mreq_in;
    mbag_preq_t  preq_out;
    mbag_sreq_t  sreq_in;
    logic        sfr_rd_out;
    logic        sfr_wr_out;
    logic [7:0]  sfr_addr_out;
    logic        mem_exc_out;
    logic        sfr_exc_out;
    int          bad_count;
    int          n_tests;

    mbag_cpu_model u_cpu (.clock_in(clock_in), .mreq_out(mreq_in), .sreq_out(sreq_in));

    mbag_guard u_dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .mode_in(mode_in),
        .fw_hw_rd_in(fw_hw_rd_in), .fw_hw_wr_in(fw_hw_wr_in), .seg_wr_en_in(seg_wr_en_in),
        .seg_wr_idx_in(seg_wr_idx_in), .seg_wr_data_in(seg_wr_data_in), .seg_sel_in(seg_sel_in),
        .mreq_in(mreq_in), .preq_out(preq_out), .sreq_in(sreq_in), .sfr_rd_out(sfr_rd_out),
        .sfr_wr_out(sfr_wr_out), .sfr_addr_out(sfr_addr_out), .mem_exc_out(mem_exc_out),
        .sfr_exc_out(sfr_exc_out));

    // clock, 20 ns period
    always #10 clock_in = ~clock_in;

    // verdict and end of run
    task automatic final_report();
        if (bad_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // compare the memory side answer
    task automatic chk_mem(input logic ok, input mbag_op_t op, input logic [15:0] pa, input logic [31:0] wd);
        logic [51:0] got;
        logic [51:0] exp;
        got = {preq_out.valid, mem_exc_out, preq_out.op, preq_out.pa, preq_out.wdata};
        exp = {ok, ~ok, op, pa, wd};
        if (!ok) got[49:0] = exp[49:0];
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // compare the register side answer
    task automatic chk_sfr(input logic ok, input logic wr, input logic [7:0] a);
        logic [10:0] got;
        logic [10:0] exp;
        got = {sfr_rd_out, sfr_wr_out, sfr_exc_out, sfr_addr_out};
        exp = {ok & ~wr, ok & wr, ~ok, a};
        if (!ok) got[7:0] = a;
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one access through the cpu model, then judge it
    task automatic mem(input mbag_op_t op, input logic [15:0] va, input logic ok, input logic [15:0] pa);
        u_cpu.mem_req(op, va);
        chk_mem(ok, op, pa, {2{va}});
    endtask

    task automatic sfr(input logic wr, input logic [7:0] a, input logic ok);
        u_cpu.sfr_req(wr, a);
        chk_sfr(ok, wr, a);
    endtask

    // load one segment entry and make it active
    task automatic seg(input logic [5:0] idx, input mbag_seg_t s);
        @(posedge clock_in);
        #1;
        seg_wr_en_in   = 1'b1;
        seg_wr_idx_in  = idx;
        seg_wr_data_in = s;
        @(posedge clock_in);
        #1;
        seg_wr_en_in = 1'b0;
        seg_sel_in   = idx;
        repeat (2) @(posedge clock_in);
    endtask

    task automatic set_mode(input mbag_mode_t m);
        @(posedge clock_in);
        #1;
        mode_in = m;
    endtask

    // cleared table: user finds no rights, firewall ignored
    task automatic t_unused_after_reset();
        set_mode(MBAG_USER);
        mem(MBAG_OP_READ, 16'h0000, 1'b0, 16'h0000);
        mem(MBAG_OP_FETCH, 16'h0040, 1'b0, 16'h0000);
        sfr(1'b0, 8'ha0, 1'b0);
    endtask

    // privileged modes pass untranslated
    task automatic t_priv_modes();
        for (int m = 0; m < 4; m++) begin
            set_mode(mbag_mode_t'(m));
            mem(MBAG_OP_READ, 16'h1234, 1'b1, 16'h1234);
            mem(MBAG_OP_WRITE, 16'hfffe, 1'b1, 16'hfffe);
            mem(MBAG_OP_FETCH, 16'h0001, 1'b1, 16'h0001);
        end
    endtask

    // user segment: rights, bounds and relocation
    task automatic t_user_segment();
        seg(6'h03, '{3'b101, 16'h1000, 16'h1fff, 16'h4000, 16'h0005, 16'h0004});
        set_mode(MBAG_USER);
        mem(MBAG_OP_READ, 16'h1000, 1'b1, 16'h5000);
        mem(MBAG_OP_FETCH, 16'h1fff, 1'b1, 16'h5fff);
        mem(MBAG_OP_WRITE, 16'h1800, 1'b0, 16'h0000);
        mem(MBAG_OP_READ, 16'h2000, 1'b0, 16'h0000);
        mem(MBAG_OP_READ, 16'h0fff, 1'b0, 16'h0000);
    endtask

    // user hw registers follow the active segment
    task automatic t_user_sfr();
        sfr(1'b0, 8'ha0, 1'b1);
        sfr(1'b1, 8'ha0, 1'b0);
        sfr(1'b1, 8'ha2, 1'b1);
        sfr(1'b0, 8'ha1, 1'b0);
        sfr(1'b1, 8'ha1, 1'b0);
    endtask

    // firmware hw registers follow the firewall
    task automatic t_fw_sfr();
        set_mode(MBAG_FW);
        fw_hw_rd_in = 16'h0002;
        fw_hw_wr_in = 16'h8000;
        sfr(1'b0, 8'ha1, 1'b1);
        sfr(1'b1, 8'ha1, 1'b0);
        sfr(1'b0, 8'ha0, 1'b0);
        sfr(1'b1, 8'haf, 1'b1);
    endtask

    // last entry without rights stays unused inside its bounds
    task automatic t_empty_segment();
        seg(6'h3f, '{3'b000, 16'h0000, 16'hffff, 16'h0100, 16'hffff, 16'hffff});
        set_mode(MBAG_USER);
        mem(MBAG_OP_READ, 16'h0100, 1'b0, 16'h0000);
        mem(MBAG_OP_FETCH, 16'h8000, 1'b0, 16'h0000);
    endtask

    // register groups against every mode
    task automatic t_mode_sfr();
        set_mode(MBAG_BOOT);
        sfr(1'b0, 8'h80, 1'b0);
        sfr(1'b1, 8'h20, 1'b1);
        sfr(1'b1, 8'h00, 1'b0);
        set_mode(MBAG_TEST);
        sfr(1'b1, 8'h80, 1'b1);
        sfr(1'b0, 8'he0, 1'b0);
        set_mode(MBAG_SYS);
        sfr(1'b1, 8'h00, 1'b1);
        sfr(1'b1, 8'h60, 1'b0);
        sfr(1'b0, 8'he0, 1'b1);
        set_mode(MBAG_FW);
        sfr(1'b1, 8'h40, 1'b0);
        sfr(1'b0, 8'h40, 1'b1);
        sfr(1'b1, 8'h60, 1'b1);
        set_mode(MBAG_USER);
        sfr(1'b1, 8'hc0, 1'b1);
    endtask

    // mid-run reset clears the table, active segment becomes unused
    task automatic t_mid_reset();
        @(posedge clock_in);
        #1;
        sys_rst_in = 1'b1;
        repeat (2) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        mem(MBAG_OP_READ, 16'h1000, 1'b0, 16'h0000);
        sfr(1'b0, 8'ha0, 1'b0);
    endtask

    // main sequence
    initial begin
        clock_in       = 1'b0;
        sys_rst_in     = 1'b1;
        mode_in        = MBAG_BOOT;
        fw_hw_rd_in    = 16'hffff;
        fw_hw_wr_in    = 16'hffff;
        seg_wr_en_in   = 1'b0;
        seg_wr_idx_in  = 6'h00;
        seg_wr_data_in = '0;
        seg_sel_in     = 6'h00;
        bad_count      = 0;
        n_tests        = 0;
        repeat (5) @(posedge clock_in);
        #1;
        sys_rst_in = 1'b0;
        t_unused_after_reset();
        t_priv_modes();
        t_user_segment();
        t_user_sfr();
        t_mid_reset();
        t_fw_sfr();
        t_mode_sfr();
        t_empty_segment();
        final_report();
    end

    // watchdog against a hang
    initial begin
        #100000;
        bad_count++;
        final_report();
    end
endmodule
`default_nettype wire
